// >>> src/byte_ops_pkg.sv
// Constants, opcode patterns, register offsets and carrier types shared by
// the byte and table-access execution unit and its opcode decoder.
// Assumes a 32-bit AHB-Lite register window decoded on haddr[7:0].
package byte_ops_pkg;

  // Register byte offsets inside the AHB-Lite window.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_INSTR = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_WREG = 8'h0c;
  localparam logic [7:0] OFS_BANK_SEL = 8'h10;
  localparam logic [7:0] OFS_TPTR = 8'h14;
  localparam logic [7:0] OFS_TLATCH = 8'h18;
  localparam logic [7:0] OFS_EADDR = 8'h1c;
  localparam logic [7:0] OFS_HOLD = 8'h20;
  localparam logic [7:0] OFS_DATA = 8'h40;

  // Field positions in control and status.
  localparam int CTRL_TWO_WORD = 0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_NEG = 1;
  localparam int STAT_ZERO = 2;
  localparam int STAT_SKIP = 3;
  localparam int STAT_DISC = 4;
  localparam int STAT_ILL = 5;
  localparam int STAT_PEND = 6;

  // Widths and reset values.
  localparam int PTR_W = 21;
  localparam int HOLD_N = 8;
  localparam logic [7:0] RST_WREG = 8'h00;
  localparam logic [3:0] RST_BANK_SEL = 4'h0;
  localparam logic [20:0] RST_PTR = 21'h000000;
  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam logic [7:0] RST_HOLD = 8'hff;
  localparam logic [7:0] RST_DATA = 8'h00;

  // Access bank: low half from bank 0, high half from the top bank.
  localparam logic [3:0] ACC_LO_BANK = 4'h0;
  localparam logic [3:0] ACC_HI_BANK = 4'hf;

  // Table pointer modes.
  localparam logic [1:0] MODE_KEEP = 2'h0;
  localparam logic [1:0] MODE_POSTINC = 2'h1;
  localparam logic [1:0] MODE_POSTDEC = 2'h2;
  localparam logic [1:0] MODE_PREINC = 2'h3;

  // Instruction cycle counts.
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TABLE = 2'h2;
  localparam logic [1:0] CYC_SKIP = 2'h2;
  localparam logic [1:0] CYC_SKIP_TWO = 2'h3;

  // Opcode patterns on the upper opcode bits.
  localparam logic [5:0] PAT_SWAP = 6'h0e;
  localparam logic [5:0] PAT_XOR_REG = 6'h06;
  localparam logic [7:0] PAT_XOR_LIT = 8'h0a;
  localparam logic [6:0] PAT_TST = 7'h33;
  localparam logic [13:0] PAT_TABLE_RD = 14'h0002;
  localparam logic [13:0] PAT_TABLE_WT = 14'h0003;

  typedef enum logic [2:0] {
    OPK_NONE = 3'h0,
    OPK_SWAP = 3'h1,
    OPK_XOR_REG = 3'h2,
    OPK_XOR_LIT = 3'h3,
    OPK_TST = 3'h4,
    OPK_TABLE_RD = 3'h5,
    OPK_TABLE_WT = 3'h6
  } op_kind_e;

  typedef struct packed {
    op_kind_e kind;
    logic dest;
    logic access;
    logic [7:0] fval;
    logic [1:0] mode;
  } decode_s;

  // One-hot phase states, one clock per phase.
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_Q1 = 5'h02,
    S_Q2 = 5'h04,
    S_Q3 = 5'h08,
    S_Q4 = 5'h10
  } phase_e;

endpackage : byte_ops_pkg

// >>> src/opcode_decoder.sv
// Opcode decoder for the byte and table-access execution unit.
// Purely combinational; the caller latches its output in the decode phase.
`timescale 1ns/1ps
module opcode_decoder (
  input wire logic [15:0] opcode,
  output byte_ops_pkg::decode_s dec
);

  // Field extraction is common to all opcodes; kind picks the operation.
  always_comb begin
    dec.dest = opcode[9];
    dec.access = opcode[8];
    dec.fval = opcode[7:0];
    dec.mode = opcode[1:0];
    if (opcode[15:10] == byte_ops_pkg::PAT_SWAP) begin
      dec.kind = byte_ops_pkg::OPK_SWAP;
    end else if (opcode[15:10] == byte_ops_pkg::PAT_XOR_REG) begin
      dec.kind = byte_ops_pkg::OPK_XOR_REG;
    end else if (opcode[15:8] == byte_ops_pkg::PAT_XOR_LIT) begin
      dec.kind = byte_ops_pkg::OPK_XOR_LIT;
    end else if (opcode[15:9] == byte_ops_pkg::PAT_TST) begin
      dec.kind = byte_ops_pkg::OPK_TST;
    end else if (opcode[15:2] == byte_ops_pkg::PAT_TABLE_RD) begin
      dec.kind = byte_ops_pkg::OPK_TABLE_RD;
    end else if (opcode[15:2] == byte_ops_pkg::PAT_TABLE_WT) begin
      dec.kind = byte_ops_pkg::OPK_TABLE_WT;
    end else begin
      dec.kind = byte_ops_pkg::OPK_NONE;
    end
  end

endmodule : opcode_decoder

// >>> src/byte_ops_exec.sv
// Execution unit for nibble swap, exclusive-OR, test-and-skip and table
// read and write, with its state reachable over an AHB-Lite slave port.
// Assumes one AHB-Lite master, single word transfers, and a program memory
// that returns a 16-bit word for the 20-bit word address it is given.
`timescale 1ns/1ps
module byte_ops_exec #(
  parameter int DATA_AW = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic [19:0] pm_addr,
  output logic pm_rd,
  input wire logic [15:0] pm_rdata
);

  localparam int DATA_WORDS = 1 << DATA_AW;

  byte_ops_pkg::phase_e state_r;
  byte_ops_pkg::decode_s dec;
  byte_ops_pkg::decode_s dec_r;
  logic [1:0] cyc_r;
  logic [1:0] ncyc_r;
  logic [15:0] instr_r;
  logic [7:0] wreg_r;
  logic [3:0] bank_select_register_r;
  logic [20:0] table_pointer_r;
  logic [7:0] table_latch_r;
  logic [11:0] eaddr_r;
  logic [7:0] opnd_r;
  logic [7:0] res_r;
  logic flag_n_r;
  logic flag_z_r;
  logic skip_r;
  logic disc_r;
  logic ill_r;
  logic two_word_r;
  logic [1:0] discard_r;
  logic [7:0] hold_r [byte_ops_pkg::HOLD_N];
  logic [7:0] mem_r [DATA_WORDS];
  logic wr_pend_r;
  logic [7:0] addr_r;
  logic hreadyout_r;
  logic hresp_r;
  logic [31:0] hrdata_r;
  logic [19:0] pm_addr_r;
  logic pm_rd_r;
  logic [31:0] rd_word;
  logic bus_we;
  logic start;
  logic is_table;
  logic first_q4;
  logic last_q4;

  // Picks the data bank: access bank by f[7], else the selected bank.
  function automatic logic [11:0] eff_addr(input logic acc,
                                           input logic [7:0] f,
                                           input logic [3:0] bank);
    if (acc) begin
      return {bank, f};
    end else if (f[7]) begin
      return {byte_ops_pkg::ACC_HI_BANK, f};
    end else begin
      return {byte_ops_pkg::ACC_LO_BANK, f};
    end
  endfunction : eff_addr

  // True when a pending bus write targets the given offset.
  function automatic logic wr_hit(input logic we, input logic [7:0] a,
                                  input logic [7:0] ofs);
    return we && (a == ofs);
  endfunction : wr_hit

  opcode_decoder u_dec (
    .opcode(instr_r),
    .dec(dec)
  );

  // Bus writes land only while the core is idle; control always lands.
  assign bus_we = wr_pend_r && (state_r == byte_ops_pkg::S_IDLE);
  assign start = wr_hit(bus_we, addr_r, byte_ops_pkg::OFS_INSTR) &&
                 (discard_r == 2'h0);
  assign is_table = (dec_r.kind == byte_ops_pkg::OPK_TABLE_RD) ||
                    (dec_r.kind == byte_ops_pkg::OPK_TABLE_WT);
  assign first_q4 = (state_r == byte_ops_pkg::S_Q4) && (cyc_r == 2'h0);
  assign last_q4 = (state_r == byte_ops_pkg::S_Q4) && (cyc_r == 2'h1);

  // AHB-Lite address phase capture; the slave never inserts wait states.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_pend_r <= 1'b0;
      addr_r <= 8'h00;
    end else if (hready) begin
      wr_pend_r <= hsel && htrans[1] && hwrite;
      addr_r <= haddr[7:0];
    end
  end

  // Handshake outputs: always ready, always OKAY.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end else begin
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end
  end

  // Read multiplexer; unmapped offsets read as zero.
  always_comb begin
    rd_word = 32'h00000000;
    if (haddr[7:6] == byte_ops_pkg::OFS_DATA[7:6]) begin
      rd_word[7:0] = mem_r[haddr[DATA_AW+1:2]];
    end else if (haddr[7:5] == byte_ops_pkg::OFS_HOLD[7:5]) begin
      rd_word[7:0] = hold_r[haddr[4:2]];
    end else begin
      case (haddr[7:0])
        byte_ops_pkg::OFS_CTRL: rd_word[0] = two_word_r;
        byte_ops_pkg::OFS_INSTR: rd_word[15:0] = instr_r;
        byte_ops_pkg::OFS_STATUS: rd_word[7:0] = {discard_r, ill_r, disc_r,
          skip_r, flag_z_r, flag_n_r, state_r != byte_ops_pkg::S_IDLE};
        byte_ops_pkg::OFS_WREG: rd_word[7:0] = wreg_r;
        byte_ops_pkg::OFS_BANK_SEL: rd_word[3:0] = bank_select_register_r;
        byte_ops_pkg::OFS_TPTR: rd_word[20:0] = table_pointer_r;
        byte_ops_pkg::OFS_TLATCH: rd_word[7:0] = table_latch_r;
        byte_ops_pkg::OFS_EADDR: rd_word[11:0] = eaddr_r;
        default: rd_word = 32'h00000000;
      endcase
    end
  end

  // Read data is registered at the address phase and stands in data phase.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hrdata_r <= 32'h00000000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata_r <= rd_word;
    end
  end

  // Phase sequencer: four clocks per instruction cycle.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= byte_ops_pkg::S_IDLE;
      cyc_r <= 2'h0;
    end else begin
      case (state_r)
        byte_ops_pkg::S_IDLE: begin
          if (start) begin
            state_r <= byte_ops_pkg::S_Q1;
          end
        end
        byte_ops_pkg::S_Q1: state_r <= byte_ops_pkg::S_Q2;
        byte_ops_pkg::S_Q2: state_r <= byte_ops_pkg::S_Q3;
        byte_ops_pkg::S_Q3: state_r <= byte_ops_pkg::S_Q4;
        byte_ops_pkg::S_Q4: begin
          if (cyc_r + 2'h1 < ncyc_r) begin
            state_r <= byte_ops_pkg::S_Q1;
            cyc_r <= cyc_r + 2'h1;
          end else begin
            state_r <= byte_ops_pkg::S_IDLE;
            cyc_r <= 2'h0;
          end
        end
        default: begin
          state_r <= byte_ops_pkg::S_IDLE;
          cyc_r <= 2'h0;
        end
      endcase
    end
  end

  // Instruction word, control bit and cycle budget.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      instr_r <= 16'h0000;
      two_word_r <= 1'b0;
      ncyc_r <= byte_ops_pkg::CYC_ONE;
    end else begin
      if (start) begin
        instr_r <= hwdata[15:0];
      end
      if (wr_hit(wr_pend_r, addr_r, byte_ops_pkg::OFS_CTRL)) begin
        two_word_r <= hwdata[byte_ops_pkg::CTRL_TWO_WORD];
      end
      if (state_r == byte_ops_pkg::S_Q1 && cyc_r == 2'h0) begin
        ncyc_r <= (dec.kind == byte_ops_pkg::OPK_TABLE_RD ||
                   dec.kind == byte_ops_pkg::OPK_TABLE_WT) ?
                  byte_ops_pkg::CYC_TABLE : byte_ops_pkg::CYC_ONE;
      end else if (state_r == byte_ops_pkg::S_Q3 && cyc_r == 2'h0 &&
                   dec_r.kind == byte_ops_pkg::OPK_TST && opnd_r == 8'h00) begin
        ncyc_r <= two_word_r ? byte_ops_pkg::CYC_SKIP_TWO :
                  byte_ops_pkg::CYC_SKIP;
      end
    end
  end

  // Decode phase: latch decode, bank-resolved address and illegal flag.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dec_r <= '0;
      eaddr_r <= 12'h000;
      ill_r <= 1'b0;
    end else if (state_r == byte_ops_pkg::S_Q1 && cyc_r == 2'h0) begin
      dec_r <= dec;
      eaddr_r <= eff_addr(dec.access, dec.fval,
                          bank_select_register_r);
      ill_r <= dec.kind == byte_ops_pkg::OPK_NONE;
    end
  end

  // Operand read in Q2, processing in Q3.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      opnd_r <= 8'h00;
      res_r <= 8'h00;
    end else if (state_r == byte_ops_pkg::S_Q2) begin
      if (cyc_r != 2'h0) begin
        opnd_r <= table_latch_r;
      end else if (dec_r.kind == byte_ops_pkg::OPK_XOR_LIT) begin
        opnd_r <= dec_r.fval;
      end else begin
        opnd_r <= mem_r[eaddr_r[DATA_AW-1:0]];
      end
    end else if (state_r == byte_ops_pkg::S_Q3 && cyc_r == 2'h0) begin
      if (dec_r.kind == byte_ops_pkg::OPK_SWAP) begin
        res_r <= {opnd_r[3:0], opnd_r[7:4]};
      end else begin
        res_r <= wreg_r ^ opnd_r;
      end
    end
  end

  // Working register: bus write when idle, literal exclusive-OR result, or result with destination 0.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wreg_r <= byte_ops_pkg::RST_WREG;
    end else if (wr_hit(bus_we, addr_r, byte_ops_pkg::OFS_WREG)) begin
      wreg_r <= hwdata[7:0];
    end else if (first_q4 &&
                 (dec_r.kind == byte_ops_pkg::OPK_XOR_LIT ||
                  ((dec_r.kind == byte_ops_pkg::OPK_SWAP ||
                    dec_r.kind == byte_ops_pkg::OPK_XOR_REG) &&
                   !dec_r.dest))) begin
      wreg_r <= res_r;
    end
  end

  // Negative and zero flags follow only the exclusive-OR results.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flag_n_r <= 1'b0;
      flag_z_r <= 1'b0;
    end else if (wr_hit(bus_we, addr_r, byte_ops_pkg::OFS_STATUS)) begin
      flag_n_r <= hwdata[byte_ops_pkg::STAT_NEG];
      flag_z_r <= hwdata[byte_ops_pkg::STAT_ZERO];
    end else if (first_q4 && (dec_r.kind == byte_ops_pkg::OPK_XOR_LIT ||
                              dec_r.kind == byte_ops_pkg::OPK_XOR_REG)) begin
      flag_n_r <= res_r[7];
      flag_z_r <= res_r == 8'h00;
    end
  end

  // Bank select register.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bank_select_register_r <= byte_ops_pkg::RST_BANK_SEL;
    end else if (wr_hit(bus_we, addr_r, byte_ops_pkg::OFS_BANK_SEL)) begin
      bank_select_register_r <= hwdata[3:0];
    end
  end

  // Data file; result with destination 1 goes back to the addressed byte.
  generate
    for (genvar i = 0; i < DATA_WORDS; i++) begin : g_mem
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          mem_r[i] <= byte_ops_pkg::RST_DATA;
        end else if (wr_hit(bus_we, {addr_r[7:6], 6'h00},
                            byte_ops_pkg::OFS_DATA) &&
                     addr_r[DATA_AW+1:2] == DATA_AW'(i)) begin
          mem_r[i] <= hwdata[7:0];
        end else if (first_q4 && dec_r.dest &&
                     eaddr_r[DATA_AW-1:0] == DATA_AW'(i) &&
                     (dec_r.kind == byte_ops_pkg::OPK_SWAP ||
                      dec_r.kind == byte_ops_pkg::OPK_XOR_REG)) begin
          mem_r[i] <= res_r;
        end
      end
    end
  endgenerate

  // Skip decision and the count of fetched words still to be flushed.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      skip_r <= 1'b0;
      disc_r <= 1'b0;
      discard_r <= 2'h0;
    end else if (state_r == byte_ops_pkg::S_Q3 && cyc_r == 2'h0 &&
                 dec_r.kind == byte_ops_pkg::OPK_TST) begin
      skip_r <= opnd_r == 8'h00;
      if (opnd_r == 8'h00) begin
        discard_r <= two_word_r ? 2'h2 : 2'h1;
      end
    end else if (wr_hit(bus_we, addr_r, byte_ops_pkg::OFS_INSTR)) begin
      if (discard_r != 2'h0) begin
        discard_r <= discard_r - 2'h1;
        disc_r <= 1'b1;
      end else begin
        disc_r <= 1'b0;
      end
    end
  end

  // Table pointer: bus load, pre-increment in cycle 1, post-step in cycle 2.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      table_pointer_r <= byte_ops_pkg::RST_PTR;
    end else if (wr_hit(bus_we, addr_r, byte_ops_pkg::OFS_TPTR)) begin
      table_pointer_r <= hwdata[byte_ops_pkg::PTR_W-1:0];
    end else if (is_table && first_q4 &&
                 dec_r.mode == byte_ops_pkg::MODE_PREINC) begin
      table_pointer_r <= table_pointer_r + 21'h1;
    end else if (is_table && last_q4) begin
      if (dec_r.mode == byte_ops_pkg::MODE_POSTINC) begin
        table_pointer_r <= table_pointer_r + 21'h1;
      end else if (dec_r.mode == byte_ops_pkg::MODE_POSTDEC) begin
        table_pointer_r <= table_pointer_r - 21'h1;
      end
    end
  end

  // Program memory read strobe in Q2 of the second table read cycle.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pm_rd_r <= 1'b0;
      pm_addr_r <= 20'h00000;
    end else begin
      pm_rd_r <= state_r == byte_ops_pkg::S_Q1 && cyc_r == 2'h1 &&
                 dec_r.kind == byte_ops_pkg::OPK_TABLE_RD;
      if (state_r == byte_ops_pkg::S_Q1 && cyc_r == 2'h1) begin
        pm_addr_r <= table_pointer_r[20:1];
      end
    end
  end

  // Table latch: bus load, or byte of the fetched word picked by bit 0.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      table_latch_r <= byte_ops_pkg::RST_LATCH;
    end else if (wr_hit(bus_we, addr_r, byte_ops_pkg::OFS_TLATCH)) begin
      table_latch_r <= hwdata[7:0];
    end else if (last_q4 && dec_r.kind == byte_ops_pkg::OPK_TABLE_RD) begin
      table_latch_r <= table_pointer_r[0] ? pm_rdata[15:8] :
                       pm_rdata[7:0];
    end
  end

  // Holding registers filled by table writes, indexed by pointer[2:0].
  generate
    for (genvar h = 0; h < byte_ops_pkg::HOLD_N; h++) begin : g_hold
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          hold_r[h] <= byte_ops_pkg::RST_HOLD;
        end else if (last_q4 && dec_r.kind == byte_ops_pkg::OPK_TABLE_WT &&
                     table_pointer_r[2:0] == 3'(h)) begin
          hold_r[h] <= opnd_r;
        end
      end
    end
  endgenerate

  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;
  assign hrdata = hrdata_r;
  assign pm_addr = pm_addr_r;
  assign pm_rd = pm_rd_r;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  a_phase_order: assert property ((state_r == byte_ops_pkg::S_Q1) |=>
    (state_r == byte_ops_pkg::S_Q2) ##1 (state_r == byte_ops_pkg::S_Q3)
    ##1 (state_r == byte_ops_pkg::S_Q4))
    else $error("phase order broken");
  a_swap_flags: assert property ((first_q4 &&
    dec_r.kind != byte_ops_pkg::OPK_XOR_LIT &&
    dec_r.kind != byte_ops_pkg::OPK_XOR_REG) |=> $stable(flag_n_r) &&
    $stable(flag_z_r)) else $error("flags changed by non-xor opcode");
  a_dest_wreg: assert property ((first_q4 && !dec_r.dest &&
    dec_r.kind == byte_ops_pkg::OPK_SWAP) |=>
    wreg_r == {$past(opnd_r[3:0]), $past(opnd_r[7:4])})
    else $error("swap result not in working register");
  a_bank_access: assert property ((state_r == byte_ops_pkg::S_Q2 &&
    cyc_r == 2'h0 && !dec_r.access) |->
    eaddr_r[11:8] == (dec_r.fval[7] ? byte_ops_pkg::ACC_HI_BANK :
    byte_ops_pkg::ACC_LO_BANK)) else $error("access bank not used");
  a_xor_flags: assert property ((state_r == byte_ops_pkg::S_Q2 &&
    cyc_r == 2'h0 && dec_r.kind == byte_ops_pkg::OPK_XOR_LIT) ##2 1'b1 |=>
    flag_z_r == (wreg_r == 8'h00) && flag_n_r == wreg_r[7])
    else $error("xor flags do not match result");
  a_table_len: assert property ((state_r == byte_ops_pkg::S_Q2 &&
    cyc_r == 2'h0 && is_table) |-> ##6 last_q4 ##1
    (state_r == byte_ops_pkg::S_IDLE)) else $error("table op not two cycles");
  a_pm_addr: assert property (pm_rd_r |->
    pm_addr_r == table_pointer_r[20:1] ##2 last_q4)
    else $error("program read address or timing wrong");
  a_preinc: assert property ((is_table && first_q4 &&
    dec_r.mode == byte_ops_pkg::MODE_PREINC) |=>
    table_pointer_r == $past(table_pointer_r) + 21'h1)
    else $error("pre-increment missing");
  a_hold_write: assert property ((last_q4 &&
    dec_r.kind == byte_ops_pkg::OPK_TABLE_WT) |=>
    hold_r[$past(table_pointer_r[2:0])] == $past(table_latch_r))
    else $error("holding register not written from latch");
  a_skip_len: assert property ((first_q4 && skip_r &&
    dec_r.kind == byte_ops_pkg::OPK_TST) |=> (state_r == byte_ops_pkg::S_Q1)
    ##3 (discard_r == (two_word_r ? 2'h2 : 2'h1)))
    else $error("skip does not flush");

  c_swap: cover property (first_q4 && dec_r.kind == byte_ops_pkg::OPK_SWAP);
  c_table_rd: cover property (last_q4 &&
    dec_r.kind == byte_ops_pkg::OPK_TABLE_RD);
  c_table_wt: cover property (last_q4 &&
    dec_r.kind == byte_ops_pkg::OPK_TABLE_WT);
  c_skip_two: cover property (first_q4 && skip_r && two_word_r);

endmodule : byte_ops_exec

// >>> tb/prog_mem_model.sv
// Program memory model: answers each read request with a word made from
// its address. Assumes requests are one-clock pulses, eight clocks apart.
`timescale 1ns/1ps
module prog_mem_model (
  input wire logic sys_clk,
  input wire logic [19:0] pm_addr,
  input wire logic pm_rd,
  output logic [15:0] pm_rdata
);
  logic [1:0] age_r = 2'h0;
  logic [15:0] word;

  // Age of the pending read; valid data stand only at age two.
  always_ff @(posedge sys_clk) begin
    if (pm_rd) age_r <= 2'h1;
    else if (age_r != 2'h0) age_r <= age_r + 2'h1;
  end

  // Outside the hold window the inverted word shows, so stale use fails.
  assign word = {pm_addr[7:0] ^ 8'h3c, pm_addr[7:0]};
  assign pm_rdata = (age_r == 2'h2) ? word : ~word;
endmodule : prog_mem_model

// >>> tb/test_byte_ops_table_access_exec.sv
// Self-checking bench for the execution unit, driven over AHB-Lite.
// Assumes zero-wait-state slave and the program memory model beside it.
`timescale 1ns/1ps
`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin fails++; \
  $display("ERROR %s expected %h seen %h", nm, e, s); end end
module test_byte_ops_table_access_exec;
  logic sys_clk, rst, hsel, hwrite, hready, hreadyout, hresp, pm_rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [19:0] pm_addr, w;
  logic [15:0] pm_rdata;
  logic [20:0] p, q;
  logic [7:0] e;
  int fails = 0;
  int check_count = 0;

  assign hready = hreadyout;
  byte_ops_exec uut (.sys_clk(sys_clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .pm_addr(pm_addr), .pm_rd(pm_rd),
    .pm_rdata(pm_rdata));
  prog_mem_model pm (.sys_clk(sys_clk), .pm_addr(pm_addr), .pm_rd(pm_rd),
    .pm_rdata(pm_rdata));

  // One single-word transfer; read data taken at the data-phase edge.
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge sys_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  // Reads a register and compares the masked value.
  task automatic ck(input string nm, input logic [7:0] a,
                    input logic [31:0] x, input logic [31:0] mk = '1);
    bus(1'b0, a, 32'h0);
    `CHK(nm, x, rd & mk)
  endtask : ck

  // Issues one opcode and polls busy until it clears.
  task automatic run(input logic [15:0] op);
    int n;
    bus(1'b1, byte_ops_pkg::OFS_INSTR, {16'h0, op});
    n = 0;
    do begin
      bus(1'b0, byte_ops_pkg::OFS_STATUS, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 40);
    `CHK("busy_clear", 1'b0, rd[0])
  endtask : run

  // Prints the counts and the verdict, then stops.
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  // Clock at 40 MHz.
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Watchdog well beyond the expected run length.
  initial begin
    #250000;
    fails++;
    final_report;
  end

  // Main sequence.
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    ck("hold_reset", byte_ops_pkg::OFS_HOLD, 32'hff);
    bus(1'b1, 8'h4c, 32'h53);
    bus(1'b1, byte_ops_pkg::OFS_STATUS, 32'h6);
    run(16'h3a03);
    ck("swap_f", 8'h4c, 32'h35);
    ck("swap_flags", byte_ops_pkg::OFS_STATUS, 32'h6, 32'h6);
    run(16'h3803);
    ck("swap_w", byte_ops_pkg::OFS_WREG, 32'h53);
    bus(1'b1, byte_ops_pkg::OFS_WREG, 32'hb5);
    run(16'h0aaf);
    ck("xor_literal_op", byte_ops_pkg::OFS_WREG, 32'h1a);
    ck("xor_literal_op_nz", byte_ops_pkg::OFS_STATUS, 32'h0, 32'h6);
    run(16'h0a1a);
    ck("xor_literal_op_z", byte_ops_pkg::OFS_STATUS, 32'h4, 32'h6);
    bus(1'b1, byte_ops_pkg::OFS_BANK_SEL, 32'h5);
    bus(1'b1, byte_ops_pkg::OFS_WREG, 32'hb5);
    run(16'h1b23);
    ck("xor_register_op_f", 8'h4c, 32'h80);
    ck("xor_register_op_n", byte_ops_pkg::OFS_STATUS, 32'h2, 32'h6);
    ck("bank_bsr", byte_ops_pkg::OFS_EADDR, 32'h523);
    run(16'h1890);
    ck("bank_acc", byte_ops_pkg::OFS_EADDR, 32'hf90);
    run(16'h6605);
    ck("skip", byte_ops_pkg::OFS_STATUS, 32'h8, 32'h8);
    run(16'h0aff);
    ck("w_kept", byte_ops_pkg::OFS_WREG, 32'hb5);
    bus(1'b1, byte_ops_pkg::OFS_CTRL, 32'h1);
    run(16'h6605);
    run(16'h0aff);
    run(16'h0aff);
    run(16'h0a01);
    ck("skip_two", byte_ops_pkg::OFS_WREG, 32'hb4);
    run(16'h6603);
    ck("no_skip", byte_ops_pkg::OFS_STATUS, 32'h0, 32'h8);
    run(16'h0a01);
    ck("no_skip_w", byte_ops_pkg::OFS_WREG, 32'hb5);
    // Base pointer sits at the top of the space so post-increment and post-decrement both wrap.
    for (int m = 0; m < 4; m++) begin
      p = 21'h1ffffe + m[20:0];
      q = (m == 3) ? p + 21'h1 : p;
      w = q[20:1];
      e = q[0] ? w[7:0] ^ 8'h3c : w[7:0];
      bus(1'b1, byte_ops_pkg::OFS_TPTR, {11'h0, p});
      run(16'h0008 | m[15:0]);
      ck("rd_latch", byte_ops_pkg::OFS_TLATCH, {24'h0, e});
      p = p + ((m == 0) ? 21'h0 : (m == 2) ? 21'h1fffff : 21'h1);
      ck("rd_ptr", byte_ops_pkg::OFS_TPTR, {11'h0, p});
      bus(1'b1, byte_ops_pkg::OFS_TPTR,
          {11'h0, q - ((m == 3) ? 21'h1 : 21'h0)});
      bus(1'b1, byte_ops_pkg::OFS_TLATCH, 32'h50 + m);
      run(16'h000c | m[15:0]);
      ck("wt_hold", 8'h20 + {q[2:0], 2'h0}, 32'h50 + m);
      ck("wt_ptr", byte_ops_pkg::OFS_TPTR, {11'h0, p});
    end
    final_report;
  end
endmodule : test_byte_ops_table_access_exec
